// ---- adc_model.sv ----
// Converter on the shared bus: returns a reply word, captures the sent word.
// Mode 0 framing, clock idle low; ready rises about 40 ns after convert falls.
`timescale 1ns/1ps
module adc_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic conv,
  input wire logic [7:0] reply,
  output logic miso,
  output logic rdy,
  output logic [7:0] got
);
  logic [7:0] sr = 8'h00;
  initial rdy = 1'b0;
  initial got = 8'h00;
  // Deselected output is driven low, not released to a pull-down
  assign miso = !cs_n && sr[7];
  always @(negedge cs_n)
  begin
    sr = reply;
    rdy = 1'b0;
  end
  always @(posedge sclk) if (!cs_n) got = {got[6:0], mosi};
  always @(negedge sclk) if (!cs_n) sr = {sr[6:0], 1'b0};
  // Kept off the core clock edge to avoid a sampling race
  always @(negedge conv) rdy <= #41 1'b1;
endmodule // adc_model

// ---- spi_master_sva.sv ----
// Checker for the serial master: select, clock, frame and pin-float relations.
// Bound to spi_stream_master; sees its ports only.
`timescale 1ns/1ps
`include "spi_stream_cfg.svh"
module spi_master_sva
  import spi_stream_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SUSPEND,
  input wire spi_cfg_t SPI_CFG,
  input wire logic STREAM_EN,
  input wire logic RX_VALID,
  input wire logic BUSY,
  input wire logic SCLK_O,
  input wire logic SCLK_OE,
  input wire logic MOSI_OE,
  input wire logic [`CS_LINES-1:0] CS_N_O,
  input wire logic [`CS_LINES-1:0] CS_OE,
  input wire logic [`DIO_LINES-1:0] DIO_DIR,
  input wire logic [`DIO_LINES-1:0] DIO_OE
);
  logic sclk_q;
  logic [9:0] gap_reg;
  logic [7:0] edge_reg;
  wire sclk_chg = SCLK_O != sclk_q;
  // Released selects clear the edge count, so each frame is counted alone
  always_ff @(posedge CLK)
  begin
    sclk_q <= SCLK_O;
    gap_reg <= sclk_chg ? 10'h000 : gap_reg + 10'h001;
    edge_reg <= &CS_N_O ? 8'h00 : edge_reg + {7'h00, sclk_chg};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_std_idle;
    !BUSY && !STREAM_EN && !SUSPEND && $stable(DIO_DIR);
  endsequence
  a_susp_float: assert property (SUSPEND [*3] |-> !SCLK_OE && !MOSI_OE && CS_OE == 8'h00 && DIO_OE == 8'h00)
    else $error("pins driven in suspend");
  a_one_select: assert property ($onehot0(~CS_N_O)) else $error("two selects low");
  a_cs_lead: assert property ($changed(SCLK_O) |-> !(&CS_N_O)) else $error("clock edge outside select");
  a_rx_pulse: assert property (RX_VALID |=> !RX_VALID) else $error("rx valid too long");
  a_clk_rate: assert property ($changed(SCLK_O) |=> $stable(SCLK_O)) else $error("clock above limit");
  a_half_period: assert property ($changed(SCLK_O) && edge_reg != 8'h00 |->
    gap_reg == 2 * (SPI_CFG.divisor + 10'h001) - 10'h001) else $error("half period wrong");
  a_edge_count: assert property ($rose(&CS_N_O) |-> edge_reg == 8'(2 * WIDTH)) else $error("edge count");
  a_dio_dir: assert property (s_std_idle [*3] |-> DIO_OE == DIO_DIR) else $error("dio direction");
endmodule // spi_master_sva

bind spi_stream_master spi_master_sva #(.WIDTH(WIDTH)) chk (.CLK, .NRST, .SUSPEND, .SPI_CFG, .STREAM_EN,
  .RX_VALID, .BUSY, .SCLK_O, .SCLK_OE, .MOSI_OE, .CS_N_O, .CS_OE, .DIO_DIR, .DIO_OE);

// ---- spi_stream_cfg.svh ----
// Timing counts and reset values for the stream-capable serial master.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef SPI_STREAM_CFG_SVH
`define SPI_STREAM_CFG_SVH
`define CLK_PERIOD_PS 5000
`define SCLK_MAX_MHZ 50
`define SCLK_HALF_MIN_CYC ((1000000 / `SCLK_MAX_MHZ / 2 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STREAM_STEP_NS 10
`define STREAM_STEP_CYC ((`STREAM_STEP_NS * 1000) / `CLK_PERIOD_PS)
`define CS_IDLE_LEVEL 1'b1
`define DIO_DIR_RESET 8'h00
`define DIO_LINES 8
`define CS_LINES 8
`define CONVERT_BIT 0
`define READY_BIT 1
`endif

// ---- spi_stream_master.sv ----
// Serial master with standard write/read transactions and a hardware-timed stream loop,
// plus eight general digital lines. Assumes MISO and digital inputs are asynchronous pins.
// Contract
// RL1 - Serial clock runs at most 50 MHz.
// RL2 - Slower serial clock comes from a configured divisor of the fastest rate.
// RL3 - One shared clock, data-out and data-in line serve every peripheral.
// RL4 - One select line per peripheral, each addressing only its own device.
// RL5 - Two modes: standard transactions and hardware-timed streaming.
// RL6 - Standard mode shifts data out while capturing returned data.
// RL7 - Select zero may be hardware timed, locked to clock and data.
// RL8 - In stream mode line one is sample ready, line zero is convert.
// RL9 - Stream waveform timings count in 10 ns steps.
// RL10 - Stream mode repeats its waveform without software pacing.
// RL11 - Standard and stream operation can follow one another.
// RL12 - Each digital line is separately input or push-pull output.
// RL13 - At startup and suspend all serial, select and digital lines float.
// RL14 - Select asserts before first edge, releases after last; one at a time.
`timescale 1ns/1ps
`include "spi_stream_cfg.svh"
module spi_stream_master
  import spi_stream_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SUSPEND,
  input wire spi_cfg_t SPI_CFG,
  input wire stream_cfg_t STREAM_CFG,
  input wire logic STREAM_EN,
  input wire logic START,
  input wire logic [WIDTH-1:0] TX_DATA,
  output logic [WIDTH-1:0] RX_DATA,
  output logic RX_VALID,
  output logic BUSY,
  output logic SCLK_O,
  output logic SCLK_OE,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic [`CS_LINES-1:0] CS_N_O,
  output logic [`CS_LINES-1:0] CS_OE,
  input wire logic [`DIO_LINES-1:0] DIO_DIR,
  input wire logic [`DIO_LINES-1:0] DIO_WR,
  output logic [`DIO_LINES-1:0] DIO_RD,
  input wire logic [`DIO_LINES-1:0] DIO_I,
  output logic [`DIO_LINES-1:0] DIO_O,
  output logic [`DIO_LINES-1:0] DIO_OE
);
  // Shifter slices WIDTH-2, and the bit counter is six bits wide
  if (WIDTH < 2 || WIDTH > 32)
  begin : g_width_check
    $error("WIDTH must lie in 2..32");
  end

  localparam logic [15:0] HALF_MIN = 16'(`SCLK_HALF_MIN_CYC);
  localparam logic [1:0] STEP_CYC = 2'(`STREAM_STEP_CYC);

  seq_state_t state_reg, state_next;
  logic [1:0] miso_sync_reg;
  logic [`DIO_LINES-1:0] dio_meta_reg, dio_sync_reg;
  logic [15:0] div_cnt_reg;
  logic [1:0] step_cnt_reg;
  logic [15:0] period_cnt_reg;
  logic [7:0] conv_cnt_reg;
  logic [5:0] bit_cnt_reg;
  logic phase_reg;
  logic stream_reg;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] rx_reg;
  logic rx_valid_reg;
  logic sclk_reg;
  logic mosi_reg;
  logic [`CS_LINES-1:0] cs_n_reg;
  logic conv_reg;
  logic drive_reg;
  spi_cfg_t cfg_reg;

  // Half period scales with divisor; divisor zero gives the 50 MHz ceiling
  wire [15:0] half_cyc = HALF_MIN * (16'(cfg_reg.divisor) + 16'h0001); // RL1 RL2
  wire half_tick = (div_cnt_reg == half_cyc - 16'h0001);
  wire step_tick = (step_cnt_reg == STEP_CYC - 2'h1); // RL9
  wire conv_start = (state_next == ST_CONV) && (state_reg != ST_CONV);
  wire in_frame = (state_reg == ST_LEAD) || (state_reg == ST_SHIFT) || (state_reg == ST_TRAIL);
  wire last_bit = (bit_cnt_reg == 6'(WIDTH - 1));
  wire sample_ready = dio_sync_reg[`READY_BIT]; // RL8
  // Done one step early so the step count equals the configured value exactly
  wire period_done = (17'(period_cnt_reg) + 17'h00001 >= 17'(STREAM_CFG.period));
  wire conv_done = (9'(conv_cnt_reg) + 9'h001 >= 9'(STREAM_CFG.conv_width));
  wire [`CS_LINES-1:0] sel_onehot = `CS_LINES'(1) << cfg_reg.select;
  // Stream frames always use select zero; standard frames use one decoded line
  wire [`CS_LINES-1:0] frame_cs = stream_reg ? `CS_LINES'(1) : sel_onehot; // RL4 RL7 RL14
  wire [`CS_LINES-1:0] cs_n_next = in_frame ? ~frame_cs : {`CS_LINES{`CS_IDLE_LEVEL}};
  wire dir_conv = stream_reg | DIO_DIR[`CONVERT_BIT];
  wire [`DIO_LINES-1:0] dio_dir_eff = stream_reg
    ? {DIO_DIR[`DIO_LINES-1:2], 1'b0, 1'b1} : DIO_DIR; // RL8 RL12
  wire [`DIO_LINES-1:0] dio_val_eff = stream_reg
    ? {DIO_WR[`DIO_LINES-1:1], conv_reg} : DIO_WR;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (STREAM_EN)
          state_next = ST_CONV; // RL5 RL11
        else if (START)
          state_next = ST_LEAD; // RL6
      ST_CONV:
        if (step_tick && conv_done)
          state_next = ST_WAIT_RDY;
      ST_WAIT_RDY:
        if (!STREAM_EN)
          state_next = ST_IDLE;
        else if (sample_ready)
          state_next = ST_LEAD;
      ST_LEAD:
        if (half_tick)
          state_next = ST_SHIFT;
      ST_SHIFT:
        if (half_tick && phase_reg && last_bit)
          state_next = ST_TRAIL;
      ST_TRAIL:
        if (half_tick)
          state_next = stream_reg ? ST_GAP : ST_IDLE;
      ST_GAP:
        if (!STREAM_EN)
          state_next = ST_IDLE;
        else if (step_tick && period_done)
          state_next = ST_CONV; // RL10
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Two-stage synchronisers for pins from outside the clock domain
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      miso_sync_reg <= 2'h0;
      dio_meta_reg <= 8'h00;
      dio_sync_reg <= 8'h00;
    end
    else
    begin
      miso_sync_reg <= {miso_sync_reg[0], MISO_I};
      dio_meta_reg <= DIO_I;
      dio_sync_reg <= dio_meta_reg;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      div_cnt_reg <= 16'h0000;
      step_cnt_reg <= 2'h0;
    end
    else
    begin
      div_cnt_reg <= (!in_frame || half_tick) ? 16'h0000 : div_cnt_reg + 16'h0001;
      // Step grid restarts at each convert so widths do not depend on phase
      step_cnt_reg <= (step_tick || conv_start) ? 2'h0 : step_cnt_reg + 2'h1; // RL9
    end
  end

  // Period counts from each convert start so frames repeat on a fixed grid
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      period_cnt_reg <= 16'h0000;
      conv_cnt_reg <= 8'h00;
    end
    else
    begin
      if (state_reg == ST_IDLE || conv_start)
        period_cnt_reg <= 16'h0000;
      else if (step_tick && !period_done)
        period_cnt_reg <= period_cnt_reg + 16'h0001; // RL9
      if (state_reg != ST_CONV)
        conv_cnt_reg <= 8'h00;
      else if (step_tick && !conv_done)
        conv_cnt_reg <= conv_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      state_reg <= ST_IDLE;
      stream_reg <= 1'b0;
      cfg_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      // Config is latched only between frames so the clock never glitches mid-word
      if (state_reg == ST_IDLE)
      begin
        cfg_reg <= SPI_CFG;
        stream_reg <= STREAM_EN;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      shift_reg <= '0;
      bit_cnt_reg <= 6'h00;
      phase_reg <= 1'b0;
      rx_reg <= '0;
      rx_valid_reg <= 1'b0;
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
    end
    else
    begin
      rx_valid_reg <= 1'b0;
      if (state_reg == ST_IDLE || state_reg == ST_WAIT_RDY || state_reg == ST_GAP)
      begin
        shift_reg <= TX_DATA;
        mosi_reg <= TX_DATA[WIDTH-1];
        bit_cnt_reg <= 6'h00;
        phase_reg <= 1'b0;
        sclk_reg <= SPI_CFG.cpol;
      end
      else if (state_reg == ST_SHIFT && half_tick)
      begin
        phase_reg <= ~phase_reg;
        sclk_reg <= ~sclk_reg;
        // Capture on the trailing tick: pin register and sync add three cycles,
        // so only then has the bit shown at the leading edge reached the sampler
        if (phase_reg)
        begin
          shift_reg <= {shift_reg[WIDTH-2:0], miso_sync_reg[1]}; // RL3 RL6
          if (!last_bit)
          begin
            mosi_reg <= shift_reg[WIDTH-2];
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
          end
        end
      end
      if (state_reg == ST_TRAIL && half_tick)
      begin
        rx_reg <= shift_reg;
        rx_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      cs_n_reg <= {`CS_LINES{`CS_IDLE_LEVEL}};
      conv_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else
    begin
      cs_n_reg <= cs_n_next; // RL14
      conv_reg <= (state_next == ST_CONV); // RL8
      drive_reg <= ~SUSPEND; // RL13
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      SCLK_O <= 1'b0;
      MOSI_O <= 1'b0;
      SCLK_OE <= 1'b0;
      MOSI_OE <= 1'b0;
      CS_N_O <= {`CS_LINES{`CS_IDLE_LEVEL}};
      CS_OE <= 8'h00;
      DIO_O <= 8'h00;
      DIO_OE <= `DIO_DIR_RESET;
      DIO_RD <= 8'h00;
      RX_DATA <= '0;
      RX_VALID <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      SCLK_O <= sclk_reg;
      MOSI_O <= mosi_reg;
      SCLK_OE <= drive_reg; // RL13
      MOSI_OE <= drive_reg;
      CS_N_O <= cs_n_reg;
      CS_OE <= {`CS_LINES{drive_reg}};
      DIO_O <= dio_val_eff;
      DIO_OE <= drive_reg ? (dio_dir_eff | {{(`DIO_LINES-1){1'b0}}, dir_conv & stream_reg}) : 8'h00; // RL12 RL13
      DIO_RD <= dio_sync_reg;
      RX_DATA <= rx_reg;
      RX_VALID <= rx_valid_reg;
      BUSY <= (state_reg != ST_IDLE);
    end
  end
endmodule // spi_stream_master

// ---- spi_stream_pkg.sv ----
// Types shared by the serial master: configuration carriers and sequencer states.
// No constants here; figures live in spi_stream_cfg.svh.
package spi_stream_pkg;
  typedef struct packed {
    logic cpol;
    logic [7:0] divisor;
    logic [2:0] select;
  } spi_cfg_t;

  typedef struct packed {
    logic hw_cs0;
    logic [15:0] period;
    logic [7:0] conv_width;
  } stream_cfg_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CONV = 7'b0000010,
    ST_WAIT_RDY = 7'b0000100,
    ST_LEAD = 7'b0001000,
    ST_SHIFT = 7'b0010000,
    ST_TRAIL = 7'b0100000,
    ST_GAP = 7'b1000000
  } seq_state_t;
endpackage

// ---- tb_top.sv ----
// Bench: frames on every select, slow divisor, digital lines, stream loop, suspend.
// Inputs change at the rising edge; results are read at the falling edge.
`timescale 1ns/1ps
`include "spi_stream_cfg.svh"
module tb_top;
  import spi_stream_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic SUSPEND = 1'b0;
  logic STREAM_EN = 1'b0;
  logic START = 1'b0;
  spi_cfg_t SPI_CFG = '0;
  stream_cfg_t STREAM_CFG = '0;
  logic [7:0] TX_DATA = 8'h00, DIO_DIR = 8'h00, DIO_WR = 8'h00, ext = 8'h00, reply = 8'h00;
  logic [7:0] RX_DATA, DIO_RD, DIO_I, DIO_O, DIO_OE, CS_N_O, CS_OE, got, seen;
  logic RX_VALID, BUSY, SCLK_O, SCLK_OE, MOSI_O, MOSI_OE, MISO_I, rdy;
  int failures = 0, n_compared = 0, frames, conv_len;
  always #2.5 CLK = ~CLK;
  // Undriven pins take the bench stimulus ext, except line 1, which follows the converter ready
  assign DIO_I = (DIO_OE & DIO_O) | (~DIO_OE & {ext[7:2], rdy, ext[0]});
  spi_stream_master #(.WIDTH(8)) dut (.CLK, .NRST, .SUSPEND, .SPI_CFG, .STREAM_CFG, .STREAM_EN, .START,
    .TX_DATA, .RX_DATA, .RX_VALID, .BUSY, .SCLK_O, .SCLK_OE, .MOSI_O, .MOSI_OE, .MISO_I, .CS_N_O, .CS_OE,
    .DIO_DIR, .DIO_WR, .DIO_RD, .DIO_I, .DIO_O, .DIO_OE);
  adc_model adc (.sclk(SCLK_OE & SCLK_O), .mosi(MOSI_OE & MOSI_O), .cs_n(&(CS_OE & CS_N_O)),
    .conv(DIO_I[0]), .reply, .miso(MISO_I), .rdy, .got);
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] act);
    n_compared++;
    if (act !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic xfer(input logic [2:0] sel, input logic [7:0] div, input logic [7:0] tx, input logic [7:0] rx);
    @(posedge CLK);
    SPI_CFG <= '{cpol: 1'b0, divisor: div, select: sel};
    TX_DATA <= tx;
    reply <= rx;
    START <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    seen = 8'h00;
    for (int i = 0; i < 3000 && !RX_VALID; i++)
    begin
      @(negedge CLK);
      seen |= ~CS_N_O;
    end
    cmp("rx_data", rx, RX_DATA);
    cmp("mosi_word", tx, got);
    cmp("select", 8'h01 << sel, seen);
    for (int i = 0; i < 100 && BUSY; i++) @(negedge CLK);
  endtask
  task automatic print_verdict();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge CLK);
    cmp("reset_pins", 8'h00, CS_OE | DIO_OE | {6'h00, SCLK_OE, MOSI_OE});
    @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    for (int s = 0; s < 8; s++) xfer(s[2:0], 8'h00, 8'ha5 ^ 8'(s), 8'h3c + 8'(s));
    xfer(3'd5, 8'h03, 8'h81, 8'h7e);
    @(posedge CLK);
    DIO_DIR <= 8'hf0;
    DIO_WR <= 8'ha4;
    ext <= 8'h3c;
    repeat (6) @(negedge CLK);
    cmp("dio_oe", 8'hf0, DIO_OE);
    cmp("dio_out", 8'ha0, DIO_O & DIO_OE);
    cmp("dio_in", 8'hac, DIO_RD);
    @(posedge CLK);
    // Select 4 asked for, yet streaming must keep to select zero
    STREAM_CFG <= '{hw_cs0: 1'b1, period: 16'd60, conv_width: 8'd3};
    SPI_CFG <= '{cpol: 1'b0, divisor: 8'h00, select: 3'd4};
    TX_DATA <= 8'h5a;
    reply <= 8'hc3;
    STREAM_EN <= 1'b1;
    for (int i = 0; i < 100 && !DIO_I[0]; i++) @(negedge CLK);
    seen = 8'h00;
    frames = 0;
    // The cycle that ended the wait is a convert cycle too
    conv_len = int'(DIO_I[0]);
    repeat (340)
    begin
      @(negedge CLK);
      frames += RX_VALID;
      conv_len += DIO_I[0];
      seen |= ~CS_N_O;
    end
    cmp("conv_cycles", 8'(9 * `STREAM_STEP_CYC), 8'(conv_len));
    cmp("frames", 8'd3, 8'(frames));
    cmp("stream_rx", 8'hc3, RX_DATA);
    cmp("stream_mosi", 8'h5a, got);
    cmp("stream_cs", 8'h01, seen);
    @(posedge CLK);
    STREAM_EN <= 1'b0;
    for (int i = 0; i < 400 && BUSY; i++) @(negedge CLK);
    xfer(3'd2, 8'h01, 8'h96, 8'h69);
    @(posedge CLK);
    SUSPEND <= 1'b1;
    repeat (3) @(negedge CLK);
    cmp("suspend_pins", 8'h00, CS_OE | DIO_OE | {6'h00, SCLK_OE, MOSI_OE});
    print_verdict();
  end
  initial
  begin
    #50000;
    failures++;
    print_verdict();
  end
endmodule // tb_top
